// file: shared/scr_pkg.sv
// What this block does
// - Remote read: code 61, lengths 06/05
// - Local read: code e1, write length 05
// - Local read length selects byte/word/dword
// - Completion code precedes any returned data
// - Remote address: bus, device, function, register
// - Local address: 4-bit bus, device, function, register
// - Originator uses bus 0000 or 0001
// - Bad local bus: zeros, passing code
// - Multi-byte fields travel least significant first
// - Unimplemented remote register may give 0x90
// - Unimplemented target may give all ones
// - Hidden local register may give 0x90
// - Pre-POST absent local function 0 gives zeros
// - Locked registers read without restriction
// - Mismatched lengths/code give aborted check byte
// - Code 0x40: passed, data valid
// - Code 0x80: response not ready in time
// - Code 0x81: no resources available now
// - Code 0x82: hardware in low power
// - Code 0x91: internal control error
// - Pass only after target replied, or for a bad local bus
// - Originator learns hub bus number first
package scr_pkg;

  // ----------------------------------------
  // Command codes and lengths
  // ----------------------------------------
  localparam logic [7:0] CMD_REMOTE = 8'h61;
  localparam logic [7:0] WL_REMOTE = 8'h06;
  localparam logic [7:0] RL_REMOTE = 8'h05;
  localparam logic [7:0] CMD_LOCAL = 8'he1;
  localparam logic [7:0] WL_LOCAL = 8'h05;
  localparam logic [7:0] RL_BYTE = 8'h02;
  localparam logic [7:0] RL_WORD = 8'h03;
  localparam logic [7:0] RL_DWORD = 8'h05;
  // Byte after the command code, ahead of the address
  localparam logic [7:0] HOST_INFO = 8'h00;

  // ----------------------------------------
  // Completion codes
  // ----------------------------------------
  localparam logic [7:0] CC_PASS = 8'h40;
  localparam logic [7:0] CC_TIMEOUT = 8'h80;
  localparam logic [7:0] CC_NO_RES = 8'h81;
  localparam logic [7:0] CC_LOW_PWR = 8'h82;
  localparam logic [7:0] CC_INVALID = 8'h90;
  localparam logic [7:0] CC_CTRL_ERR = 8'h91;

  // ----------------------------------------
  // Address fields
  // ----------------------------------------
  localparam int REM_RSV_LSB = 28;
  localparam int REM_BUS_MSB = 27;
  localparam int REM_BUS_LSB = 20;
  localparam int LOC_BUS_MSB = 23;
  localparam int LOC_BUS_LSB = 20;
  localparam int FN_MSB = 14;
  localparam int FN_LSB = 12;
  localparam logic [3:0] BUS_IIO = 4'h0;
  localparam logic [3:0] BUS_UNCORE = 4'h1;
  // Where the originator finds the hub bus number
  localparam logic [23:0] BUSNO_LOC_ADDR = 24'h1000d0;
  localparam int HUB_BUS_LSB = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESP_TIMEOUT_NS = 10000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // Target answer kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    TS_OK = 3'h0,
    TS_UNIMPL = 3'h1,
    TS_ABSENT = 3'h2,
    TS_INVALID = 3'h3,
    TS_CTRL_ERR = 3'h4
  } scr_tstat_t;

endpackage

// file: shared/scr_link_if.sv
`timescale 1ns/10ps
interface scr_link_if (
  input wire logic core_clk
);
  logic h2d_vld;
  logic [7:0] h2d_byte;
  logic h2d_end;
  logic d2h_vld;
  logic [7:0] d2h_byte;
  logic d2h_last;
  logic d2h_abort;

  modport dev (
    input h2d_vld,
    input h2d_byte,
    input h2d_end,
    output d2h_vld,
    output d2h_byte,
    output d2h_last,
    output d2h_abort
  );

  modport host (
    output h2d_vld,
    output h2d_byte,
    output h2d_end,
    input d2h_vld,
    input d2h_byte,
    input d2h_last,
    input d2h_abort
  );
endinterface

// file: design/scr_client.sv
`timescale 1ns/10ps
module scr_client (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link to originator
  scr_link_if.dev link,
  // Configuration target
  output logic tgt_req,
  output logic tgt_local,
  output logic [31:0] tgt_addr,
  output logic [7:0] tgt_rl,
  input wire logic tgt_ack,
  input wire scr_pkg::scr_tstat_t tgt_status,
  input wire logic [31:0] tgt_data,
  // Conditions
  input wire logic res_busy,
  input wire logic low_power,
  input wire logic post_done
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_WAIT = 3'b010,
    ST_TX = 3'b100
  } scr_dst_t;

  typedef struct packed {
    scr_dst_t st;
    logic [3:0] idx;
    logic [7:0] wl;
    logic [7:0] rl;
    logic [7:0] cmd;
    logic is_local;
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0] cc;
    logic [9:0] tmo;
    logic [3:0] tx_cnt;
    logic tgt_req;
    logic d2h_vld;
    logic [7:0] d2h_byte;
    logic d2h_last;
    logic d2h_abort;
  } scr_dev_t;

  scr_dev_t s_q;
  scr_dev_t s_d;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] a;
    logic [3:0] got;
    logic rem_ok;
    logic loc_ok;
    logic bad_bus;
    a = s_q.addr;
    got = s_q.idx - 4'd1;
    rem_ok = 1'b0;
    loc_ok = 1'b0;
    bad_bus = 1'b0;
    s_d = s_q;
    s_d.tgt_req = 1'b0;
    s_d.d2h_vld = 1'b0;
    s_d.d2h_last = 1'b0;
    s_d.d2h_abort = 1'b0;
    s_d.d2h_byte = 8'h00;
    // Address bytes arrive LSB first
    if (s_q.idx >= 4'd4 && s_q.idx <= 4'd7) begin
      a[{s_q.idx[1:0], 3'b000} +: 8] = link.h2d_byte;
    end
    rem_ok = s_q.cmd == scr_pkg::CMD_REMOTE && s_q.wl == scr_pkg::WL_REMOTE
      && s_q.rl == scr_pkg::RL_REMOTE && {4'h0, got} == s_q.wl;
    loc_ok = s_q.cmd == scr_pkg::CMD_LOCAL && s_q.wl == scr_pkg::WL_LOCAL
      && {4'h0, got} == s_q.wl
      && (s_q.rl == scr_pkg::RL_BYTE || s_q.rl == scr_pkg::RL_WORD
      || s_q.rl == scr_pkg::RL_DWORD);
    if (loc_ok) begin
      a[31:24] = 8'h00;
      bad_bus = a[scr_pkg::LOC_BUS_MSB:scr_pkg::LOC_BUS_LSB] != scr_pkg::BUS_IIO
        && a[scr_pkg::LOC_BUS_MSB:scr_pkg::LOC_BUS_LSB] != scr_pkg::BUS_UNCORE;
    end else begin
      a[31:scr_pkg::REM_RSV_LSB] = 4'h0;
    end
    case (s_q.st)
      ST_RX: begin
        if (link.h2d_vld) begin
          if (s_q.idx != 4'hf) begin
            s_d.idx = s_q.idx + 4'd1;
          end
          case (s_q.idx)
            4'd0: begin
              s_d.wl = link.h2d_byte;
              s_d.addr = 32'h0000_0000;
            end
            4'd1: s_d.rl = link.h2d_byte;
            4'd2: s_d.cmd = link.h2d_byte;
            default: s_d.addr = a;
          endcase
          if (link.h2d_end) begin
            s_d.idx = 4'd0;
            s_d.addr = a;
            s_d.is_local = loc_ok;
            s_d.data = 32'h0000_0000;
            s_d.tx_cnt = 4'd0;
            if (!rem_ok && !loc_ok) begin
              // Aborted check byte stands in for the whole reply
              s_d.d2h_vld = 1'b1;
              s_d.d2h_last = 1'b1;
              s_d.d2h_abort = 1'b1;
            end else if (bad_bus) begin
              // Never reaches the target
              s_d.cc = scr_pkg::CC_PASS;
              s_d.st = ST_TX;
            end else if (res_busy) begin
              s_d.cc = scr_pkg::CC_NO_RES;
              s_d.st = ST_TX;
            end else if (low_power) begin
              s_d.cc = scr_pkg::CC_LOW_PWR;
              s_d.st = ST_TX;
            end else begin
              // No lock check: locked registers read as any other
              s_d.tgt_req = 1'b1;
              s_d.tmo = 10'd0;
              s_d.st = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT: begin
        s_d.tmo = s_q.tmo + 10'd1;
        if (tgt_ack) begin
          s_d.st = ST_TX;
          s_d.cc = scr_pkg::CC_PASS;
          case (tgt_status)
            scr_pkg::TS_OK: s_d.data = tgt_data;
            scr_pkg::TS_UNIMPL: s_d.data = 32'hffff_ffff;
            scr_pkg::TS_ABSENT: begin
              if (s_q.is_local && !post_done
                  && s_q.addr[scr_pkg::FN_MSB:scr_pkg::FN_LSB] == 3'h0) begin
                s_d.data = 32'h0000_0000;
              end else begin
                s_d.data = 32'hffff_ffff;
              end
            end
            scr_pkg::TS_INVALID: s_d.cc = scr_pkg::CC_INVALID;
            scr_pkg::TS_CTRL_ERR: s_d.cc = scr_pkg::CC_CTRL_ERR;
            default: s_d.cc = scr_pkg::CC_CTRL_ERR;
          endcase
        end else if (s_q.tmo == 10'(scr_pkg::RESP_TIMEOUT_CYC - 1)) begin
          // A late acknowledge is dropped in the transmit or receive state
          s_d.cc = scr_pkg::CC_TIMEOUT;
          s_d.st = ST_TX;
        end
      end
      ST_TX: begin
        s_d.d2h_vld = 1'b1;
        s_d.tx_cnt = s_q.tx_cnt + 4'd1;
        if (s_q.tx_cnt == 4'd0) begin
          s_d.d2h_byte = s_q.cc;
        end else begin
          s_d.d2h_byte = s_q.data[7:0];
          s_d.data = {8'h00, s_q.data[31:8]};
        end
        // Read length counts the code byte too
        if ({4'h0, s_q.tx_cnt} == s_q.rl - 8'd1) begin
          s_d.d2h_last = 1'b1;
          s_d.st = ST_RX;
        end
      end
      default: s_d.st = ST_RX;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_RX;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign tgt_req = s_q.tgt_req;
  assign tgt_local = s_q.is_local;
  assign tgt_addr = s_q.addr;
  assign tgt_rl = s_q.rl;
  assign link.d2h_vld = s_q.d2h_vld;
  assign link.d2h_byte = s_q.d2h_byte;
  assign link.d2h_last = s_q.d2h_last;
  assign link.d2h_abort = s_q.d2h_abort;

endmodule

// file: design/scr_originator.sv
`timescale 1ns/10ps
module scr_originator (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link to client
  scr_link_if.host link,
  // Request
  input wire logic req_go,
  input wire logic req_local,
  input wire logic req_uncore,
  input wire logic req_hub,
  input wire logic [1:0] req_size,
  input wire logic [27:0] req_addr,
  // Result
  output logic busy,
  output logic done,
  output logic done_abort,
  output logic [7:0] done_cc,
  output logic [31:0] done_data,
  output logic hub_known,
  output logic [7:0] hub_bus
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_RECV = 3'b100
  } scr_hst_t;

  typedef struct packed {
    scr_hst_t st;
    logic [63:0] txv;
    logic [3:0] left;
    logic is_local;
    logic [23:0] addr;
    logic [3:0] rx_cnt;
    logic [7:0] cc;
    logic [31:0] data;
    logic h2d_vld;
    logic [7:0] h2d_byte;
    logic h2d_end;
    logic busy;
    logic done;
    logic done_abort;
    logic hub_known;
    logic [7:0] hub_bus;
  } scr_host_t;

  scr_host_t s_q;
  scr_host_t s_d;

  always_comb begin
    logic [31:0] ra;
    logic [23:0] la;
    logic [7:0] rl;
    logic [31:0] d;
    ra = {4'h0, (req_hub ? s_q.hub_bus : req_addr[27:20]), req_addr[19:0]};
    la = {(req_uncore ? scr_pkg::BUS_UNCORE : scr_pkg::BUS_IIO), req_addr[19:0]};
    rl = req_size == 2'd0 ? scr_pkg::RL_BYTE : req_size == 2'd1 ? scr_pkg::RL_WORD : scr_pkg::RL_DWORD;
    d = s_q.data;
    d[{s_q.rx_cnt[1:0] - 2'd1, 3'b000} +: 8] = link.d2h_byte;
    s_d = s_q;
    s_d.h2d_vld = 1'b0;
    s_d.h2d_end = 1'b0;
    s_d.h2d_byte = 8'h00;
    s_d.done = 1'b0;
    s_d.done_abort = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        // Hub targets wait until their bus number is known
        if (req_go && !(req_hub && !req_local && !s_q.hub_known)) begin
          s_d.st = ST_SEND;
          s_d.busy = 1'b1;
          s_d.is_local = req_local;
          s_d.rx_cnt = 4'd0;
          s_d.data = 32'h0000_0000;
          if (req_local) begin
            s_d.txv = {8'h00, la, scr_pkg::HOST_INFO, scr_pkg::CMD_LOCAL, rl, scr_pkg::WL_LOCAL};
            s_d.left = scr_pkg::WL_LOCAL[3:0] + 4'd2;
            s_d.addr = la;
          end else begin
            s_d.txv = {ra, scr_pkg::HOST_INFO, scr_pkg::CMD_REMOTE, scr_pkg::RL_REMOTE, scr_pkg::WL_REMOTE};
            s_d.left = scr_pkg::WL_REMOTE[3:0] + 4'd2;
            s_d.addr = ra[23:0];
          end
        end
      end
      ST_SEND: begin
        s_d.h2d_vld = 1'b1;
        s_d.h2d_byte = s_q.txv[7:0];
        s_d.txv = {8'h00, s_q.txv[63:8]};
        s_d.left = s_q.left - 4'd1;
        if (s_q.left == 4'd1) begin
          s_d.h2d_end = 1'b1;
          s_d.st = ST_RECV;
        end
      end
      ST_RECV: begin
        if (link.d2h_vld) begin
          s_d.rx_cnt = s_q.rx_cnt + 4'd1;
          if (s_q.rx_cnt == 4'd0) begin
            s_d.cc = link.d2h_byte;
          end else begin
            s_d.data = d;
          end
          if (link.d2h_abort) begin
            s_d.cc = 8'h00;
            s_d.done_abort = 1'b1;
          end
          if (link.d2h_last || link.d2h_abort) begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = ST_IDLE;
            if (!link.d2h_abort && s_q.is_local && s_q.cc == scr_pkg::CC_PASS
                && s_q.addr == scr_pkg::BUSNO_LOC_ADDR) begin
              s_d.hub_known = 1'b1;
              s_d.hub_bus = d[scr_pkg::HUB_BUS_LSB +: 8];
            end
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.h2d_vld = s_q.h2d_vld;
  assign link.h2d_byte = s_q.h2d_byte;
  assign link.h2d_end = s_q.h2d_end;
  assign busy = s_q.busy;
  assign done = s_q.done;
  assign done_abort = s_q.done_abort;
  assign done_cc = s_q.cc;
  assign done_data = s_q.data;
  assign hub_known = s_q.hub_known;
  assign hub_bus = s_q.hub_bus;

endmodule

// file: dv/scr_link_monitor.sv
`timescale 1ns/10ps
module scr_link_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request side
  input wire logic h2d_vld,
  input wire logic [7:0] h2d_byte,
  input wire logic h2d_end,
  // Reply side
  input wire logic d2h_vld,
  input wire logic [7:0] d2h_byte,
  input wire logic d2h_last,
  input wire logic d2h_abort
);
  logic [3:0] idx_q;
  logic [7:0] wl_q, rl_q, cmd_q, rc_q;
  logic first_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      idx_q <= 4'h0;
      wl_q <= 8'h00;
      rl_q <= 8'h00;
      cmd_q <= 8'h00;
      rc_q <= 8'h00;
      first_q <= 1'b0;
    end else begin
      if (h2d_vld) idx_q <= h2d_end ? 4'h0 : idx_q + 4'h1;
      if (h2d_vld && idx_q == 4'h0) wl_q <= h2d_byte;
      if (h2d_vld && idx_q == 4'h1) rl_q <= h2d_byte;
      if (h2d_vld && idx_q == 4'h2) cmd_q <= h2d_byte;
      if (h2d_vld && h2d_end) begin
        rc_q <= 8'h00;
        first_q <= 1'b1;
      end else if (d2h_vld) begin
        rc_q <= rc_q + 8'h01;
        first_q <= 1'b0;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_end;
    h2d_vld && h2d_end;
  endsequence
  // Byte count must equal write length plus two
  sequence s_good;
    (cmd_q == 8'h61 && wl_q == 8'h06 && rl_q == 8'h05 && idx_q == 4'h7) ||
    (cmd_q == 8'he1 && wl_q == 8'h05 && rl_q inside {8'h02, 8'h03, 8'h05} && idx_q == 4'h6);
  endsequence

  AST_FRAME_FORM: assert property (s_end |-> s_good)
    else $error("request frame malformed");
  AST_LOCAL_BUS: assert property (s_end and cmd_q == 8'he1 |-> h2d_byte[7:4] inside {4'h0, 4'h1})
    else $error("local bus field invalid");
  AST_REMOTE_RSV: assert property (s_end and cmd_q == 8'h61 |-> h2d_byte[7:4] == 4'h0)
    else $error("remote reserved bits set");
  AST_NO_ABORT: assert property (s_end |-> ##1 !d2h_abort)
    else $error("good frame aborted");
  AST_CC_FIRST: assert property (d2h_vld && first_q && !d2h_abort |->
    d2h_byte inside {8'h40, 8'h80, 8'h81, 8'h82, 8'h90, 8'h91})
    else $error("first reply byte not a completion code");
  AST_REPLY_LEN: assert property (d2h_last && !d2h_abort |-> d2h_vld && rc_q == rl_q - 8'h01)
    else $error("reply length wrong");
  AST_REPLY_BOUND: assert property (s_end |-> ##[1:600] d2h_vld)
    else $error("no reply in time");
  AST_LAST_IDLE: assert property (d2h_last |=> !d2h_vld [*3])
    else $error("reply bytes after last");
endmodule

// file: dv/sideband_config_read_tb_top.sv
`timescale 1ns/10ps
module sideband_config_read_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_go, req_local, req_uncore, req_hub, busy, done, done_abort, hub_known;
  logic [1:0] req_size;
  logic [27:0] req_addr;
  logic [7:0] done_cc, hub_bus, tgt_rl, cap_rl;
  logic [31:0] done_data, tgt_addr, tgt_data, cap_addr;
  logic tgt_req, tgt_local, tgt_ack, res_busy, low_power, post_done, ab_b, cap_loc;
  scr_pkg::scr_tstat_t tgt_status;
  int bad_count = 0;
  int checked = 0;
  int ack_dly = 1;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  logic [7:0] dq[$];

  always #10 core_clk = ~core_clk;

  scr_link_if link_a (.core_clk(core_clk));
  scr_link_if link_b (.core_clk(core_clk));
  scr_client i_scr_client (.core_clk, .rst, .link(link_a), .tgt_req, .tgt_local, .tgt_addr, .tgt_rl, .tgt_ack,
    .tgt_status, .tgt_data, .res_busy, .low_power, .post_done);
  // Second end faces the rule-breaking driver
  scr_client i_scr_client_b (.core_clk, .rst, .link(link_b), .tgt_req(), .tgt_local(), .tgt_addr(), .tgt_rl(),
    .tgt_ack(1'b0), .tgt_status, .tgt_data, .res_busy, .low_power, .post_done);
  scr_originator i_scr_originator (.core_clk, .rst, .link(link_a), .req_go, .req_local, .req_uncore, .req_hub,
    .req_size, .req_addr, .busy, .done, .done_abort, .done_cc, .done_data, .hub_known, .hub_bus);
  scr_link_monitor i_scr_link_monitor (.core_clk, .rst, .h2d_vld(link_a.h2d_vld), .h2d_byte(link_a.h2d_byte),
    .h2d_end(link_a.h2d_end), .d2h_vld(link_a.d2h_vld), .d2h_byte(link_a.d2h_byte),
    .d2h_last(link_a.d2h_last), .d2h_abort(link_a.d2h_abort));

  always @(posedge core_clk) begin
    if (link_a.h2d_vld === 1'b1) wq.push_back(link_a.h2d_byte);
    if (link_a.d2h_vld === 1'b1) dq.push_back(link_a.d2h_byte);
  end

  // Target: ack after ack_dly cycles, none when zero
  initial begin
    tgt_ack = 1'b0;
    forever begin
      @(posedge core_clk);
      #1;
      if (tgt_req === 1'b1) begin
        cap_addr = tgt_addr;
        cap_rl = tgt_rl;
        cap_loc = tgt_local;
        if (ack_dly > 0) begin
          repeat (ack_dly - 1) begin
            @(posedge core_clk);
            #1;
          end
          tgt_ack = 1'b1;
          @(posedge core_clk);
          #1 tgt_ack = 1'b0;
        end
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic run(input logic l, input logic u, input logic h, input logic [1:0] s, input logic [27:0] a,
    input logic [7:0] ecc, input logic [31:0] ed);
    int n;
    n = 0;
    wq = {};
    dq = {};
    req_local = l;
    req_uncore = u;
    req_hub = h;
    req_size = s;
    req_addr = a;
    req_go = 1'b1;
    @(posedge core_clk);
    #1 req_go = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(done, 1'b1);
    chk(done_cc, ecc);
    chk(done_data, ed);
    chk({busy, done_abort}, 2'b00);
  endtask

  task automatic send_b(input logic [7:0] b[$]);
    int n;
    n = 0;
    rq = {};
    foreach (b[i]) begin
      link_b.h2d_vld = 1'b1;
      link_b.h2d_byte = b[i];
      link_b.h2d_end = (i == b.size() - 1);
      @(posedge core_clk);
      #1;
    end
    link_b.h2d_vld = 1'b0;
    link_b.h2d_end = 1'b0;
    while (n < 100) begin
      if (link_b.d2h_vld === 1'b1) rq.push_back(link_b.d2h_byte);
      ab_b = link_b.d2h_abort;
      if (link_b.d2h_last === 1'b1) break;
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  task automatic t_remote;
    logic [7:0] er[8] = '{8'h06, 8'h05, 8'h61, 8'h00, 8'hc8, 8'hb7, 8'ha6, 8'h05};
    logic [7:0] ed[5] = '{8'h40, 8'h78, 8'h56, 8'h34, 8'h12};
    tgt_data = 32'h12345678;
    run(1'b0, 1'b0, 1'b0, 2'h2, 28'h5a6b7c8, 8'h40, 32'h12345678);
    chk(cap_addr, 32'h05a6b7c8);
    chk(cap_loc, 1'b0);
    chk(cap_rl, 8'h05);
    foreach (er[i]) chk(wq[i], er[i]);
    foreach (ed[i]) chk(dq[i], ed[i]);
    $display("remote read test done");
  endtask

  task automatic t_local;
    tgt_data = 32'ha1b2c3d4;
    run(1'b1, 1'b1, 1'b0, 2'h0, 28'h00abcde, 8'h40, 32'h000000d4);
    chk(cap_rl, 8'h02);
    chk(cap_addr, 32'h001abcde);
    chk(cap_loc, 1'b1);
    chk(wq.size(), 7);
    run(1'b1, 1'b0, 1'b0, 2'h1, 28'h00abcde, 8'h40, 32'h0000c3d4);
    chk(cap_rl, 8'h03);
    chk(cap_addr, 32'h000abcde);
    run(1'b1, 1'b0, 1'b0, 2'h2, 28'h00abcde, 8'h40, 32'ha1b2c3d4);
    chk(cap_rl, 8'h05);
    $display("local sizes test done");
  endtask

  task automatic t_status;
    tgt_status = scr_pkg::TS_UNIMPL;
    run(1'b0, 1'b0, 1'b0, 2'h2, 28'h0123000, 8'h40, 32'hffffffff);
    tgt_status = scr_pkg::TS_INVALID;
    run(1'b1, 1'b1, 1'b0, 2'h2, 28'h0008100, 8'h90, 32'h0);
    run(1'b0, 1'b0, 1'b0, 2'h2, 28'h0008100, 8'h90, 32'h0);
    tgt_status = scr_pkg::TS_CTRL_ERR;
    run(1'b0, 1'b0, 1'b0, 2'h2, 28'h0008100, 8'h91, 32'h0);
    tgt_status = scr_pkg::TS_ABSENT;
    run(1'b1, 1'b0, 1'b0, 2'h2, 28'h0008000, 8'h40, 32'h0);
    post_done = 1'b1;
    run(1'b1, 1'b0, 1'b0, 2'h2, 28'h0008000, 8'h40, 32'hffffffff);
    tgt_status = scr_pkg::TS_OK;
    $display("status test done");
  endtask

  task automatic t_cond;
    res_busy = 1'b1;
    run(1'b1, 1'b0, 1'b0, 2'h2, 28'h0000010, 8'h81, 32'h0);
    res_busy = 1'b0;
    low_power = 1'b1;
    run(1'b1, 1'b0, 1'b0, 2'h2, 28'h0000010, 8'h82, 32'h0);
    low_power = 1'b0;
    ack_dly = 0;
    run(1'b0, 1'b0, 1'b0, 2'h2, 28'h0000010, 8'h80, 32'h0);
    ack_dly = 40;
    run(1'b0, 1'b0, 1'b0, 2'h2, 28'h0000010, 8'h40, 32'ha1b2c3d4);
    ack_dly = 1;
    $display("conditions test done");
  endtask

  task automatic t_bad;
    send_b('{8'h05, 8'h02, 8'he1, 8'h00, 8'hde, 8'hbc, 8'h3a});
    chk(rq.size(), 2);
    chk({rq[0], rq[1], 7'h0, ab_b}, 32'h00400000);
    send_b('{8'h06, 8'h05, 8'he1, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44});
    chk({rq.size(), ab_b}, {32'd1, 1'b1});
    send_b('{8'h05, 8'h04, 8'he1, 8'h00, 8'h11, 8'h22, 8'h03});
    chk({rq[0], 7'h0, ab_b}, 16'h0001);
    $display("rule breaking test done");
  endtask

  task automatic t_hub;
    chk(hub_known, 1'b0);
    tgt_data = 32'h00003c00;
    run(1'b1, 1'b1, 1'b0, 2'h2, 28'h00000d0, 8'h40, 32'h00003c00);
    chk({hub_known, hub_bus}, 9'h13c);
    run(1'b0, 1'b0, 1'b1, 2'h2, 28'h11230f0, 8'h40, 32'h00003c00);
    chk(cap_addr, 32'h03c230f0);
    $display("hub bus test done");
  endtask

  initial begin
    {req_go, req_local, req_uncore, req_hub, res_busy, low_power, post_done} = 7'h0;
    req_size = 2'h0;
    req_addr = 28'h0;
    tgt_data = 32'h0;
    tgt_status = scr_pkg::TS_OK;
    {link_b.h2d_vld, link_b.h2d_end, link_b.h2d_byte} = 10'h0;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    t_remote;
    t_local;
    t_status;
    t_cond;
    t_bad;
    t_hub;
    finish_test;
  end

  // Whole run needs well under 6000 cycles
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
endmodule
